// ---- core/bcl_close_latch.sv ----
/*
 * Breaker close latch: set/reset latch driving the close output contact,
 * with close-failure timer, breaker status selection, reclose enable
 * setting, a plain register port and one level interrupt.
 * Assumes inputs synchronous to clk_sys; each enabled clock is one
 * processing interval; bus master obeys one-cycle strobes.
 */
// Operation
// - Set only with unlatch low, breaker open, no initiate edge, no close failure.
// - Set on qualified reclose timeout or rising edge of the close condition.
// - Clear on unlatch, breaker closed, initiate rising edge or close failure.
// - Close-failure time OFF disables the timer and its clearing.
// - Default 60 intervals: close high at most 60, then the timeout clears it and sets the failure flag.
// - Defaults: status from opto input one, close command, unlatch is trip OR diff trip.
// - Each executed close command rises the command bit, giving a close edge.
// - Close blocked for as long as either trip bit is high.
// - Status equation constant zero makes close logic and reclosing inoperable.
// - Evaluated breaker status is exposed as a status bit.
// - Normally-closed contact handled by inversion; one still means closed.
// - Reclose enable takes off or one to four reclosures.
// - Reclose off never blocks closing through the close condition.
// - Reclose timeout input needs open interval timeout and supervision met.
`timescale 1ns/1ps

module bcl_close_latch
    import bcl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [BCL_AW-1:0] reg_addr,
    input wire logic [BCL_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [BCL_DW-1:0] reg_rdata,
    input wire bcl_in_s ins,
    output logic close_output_contact,
    output logic breaker_closed_status,
    output logic close_fail_flag,
    output logic reclose_active,
    output logic irq
);

    // ---------------------------------------------------------------
    // Elaboration check
    // ---------------------------------------------------------------
    if (CNT_W < 7 || CNT_W > 16) begin : g_chk
        $error("CNT_W must lie between 7 and 16");
    end

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic close_r;
        logic cf_r;
        logic bkr_r;
        logic rcl_act_r;
        logic cl_prev_r;
        logic ri_prev_r;
        logic [CNT_W-1:0] cnt_r;
        logic cfd_off_r;
        bcl_bkr_sel_e bkr_sel_r;
        logic [2:0] rcl_r;
        logic [CNT_W-1:0] cfd_r;
        logic [BCL_IRQ_W-1:0] ist_r;
        logic [BCL_IRQ_W-1:0] imask_r;
        logic irq_r;
        logic [BCL_DW-1:0] rdata_r;
    } bcl_state_s;

    bcl_state_s st;
    bcl_state_s st_nxt;

    logic bkr_c;
    logic unlatch_close_cond_c;
    logic cl_c;
    logic cl_rise_c;
    logic ri_rise_c;
    logic inop_c;
    logic rcl_en_c;
    logic rcl_tmo_c;
    logic tmo_c;
    logic set_ok_c;
    logic set_ev_c;
    logic clr_c;
    logic [BCL_IRQ_W-1:0] ev_c;
    logic [BCL_DW-1:0] stat_c;

    // ---------------------------------------------------------------
    // Settings-driven equations
    // ---------------------------------------------------------------
    always_comb begin
        unique case (st.bkr_sel_r)
            BCL_BKR_OPTO: bkr_c = ins.opto_input_one;
            BCL_BKR_OPTO_INV: bkr_c = ~ins.opto_input_one;
            BCL_BKR_ZERO: bkr_c = 1'b0;
            BCL_BKR_ONE: bkr_c = 1'b1;
        endcase
        inop_c = (st.bkr_sel_r == BCL_BKR_ZERO);
        unlatch_close_cond_c = ins.trip_bit | ins.diff_trip_bit;
        cl_c = ins.close_cmd_bit;
        cl_rise_c = cl_c & ~st.cl_prev_r;
        ri_rise_c = ins.reclose_initiate & ~st.ri_prev_r;
        rcl_en_c = (st.rcl_r != BCL_RCL_OFF) & ~inop_c;
        rcl_tmo_c = rcl_en_c & ins.open_interval_tmo & ins.reclose_supervision_cond;
        tmo_c = st.close_r & ~st.cfd_off_r & (st.cnt_r >= st.cfd_r - 1'b1);
        set_ok_c = ~unlatch_close_cond_c & ~bkr_c & ~ri_rise_c & ~st.cf_r & ~inop_c;
        set_ev_c = rcl_tmo_c | cl_rise_c;
        clr_c = unlatch_close_cond_c | bkr_c | ri_rise_c | st.cf_r | tmo_c;
    end

    // ---------------------------------------------------------------
    // Status word and interrupt events
    // ---------------------------------------------------------------
    always_comb begin
        stat_c = '0;
        stat_c[BCL_STAT_CLOSE] = st.close_r;
        stat_c[BCL_STAT_BKR] = st.bkr_r;
        stat_c[BCL_STAT_FAIL] = st.cf_r;
        stat_c[BCL_STAT_RCL] = st.rcl_act_r;
        stat_c[BCL_STAT_INOP] = inop_c;
        ev_c = '0;
        ev_c[BCL_IRQ_SET] = ~st.close_r & set_ok_c & set_ev_c;
        ev_c[BCL_IRQ_FAIL] = tmo_c;
        ev_c[BCL_IRQ_BKR] = bkr_c & ~st.bkr_r;
    end

    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st;
        st_nxt.rdata_r = '0;
        if (ce) begin
            if (st.close_r) begin
                st_nxt.close_r = ~clr_c;
            end else begin
                st_nxt.close_r = set_ok_c & set_ev_c;
            end
            st_nxt.cf_r = tmo_c;
            if (st.close_r & ~st.cfd_off_r) begin
                st_nxt.cnt_r = st.cnt_r + 1'b1;
            end else begin
                st_nxt.cnt_r = '0;
            end
            st_nxt.bkr_r = bkr_c;
            st_nxt.rcl_act_r = rcl_en_c;
            st_nxt.cl_prev_r = cl_c;
            st_nxt.ri_prev_r = ins.reclose_initiate;
            if (reg_rd && reg_addr == BCL_ISTAT_ADDR) begin
                st_nxt.ist_r = ev_c;
            end else begin
                st_nxt.ist_r = st.ist_r | ev_c;
            end
            if (reg_wr) begin
                unique case (reg_addr)
                    BCL_CTRL_ADDR: begin
                        st_nxt.cfd_off_r = reg_wdata[BCL_CTRL_CFD_OFF];
                        st_nxt.bkr_sel_r = bcl_bkr_sel_e'(reg_wdata[BCL_CTRL_BKR_LSB +: 2]);
                        if (reg_wdata[BCL_CTRL_RCL_LSB +: 3] <= BCL_RCL_MAX) begin
                            st_nxt.rcl_r = reg_wdata[BCL_CTRL_RCL_LSB +: 3];
                        end
                    end
                    BCL_CFD_ADDR: begin
                        if (reg_wdata[CNT_W-1:0] != '0) begin
                            st_nxt.cfd_r = reg_wdata[CNT_W-1:0];
                        end
                    end
                    BCL_IMASK_ADDR: st_nxt.imask_r = reg_wdata[BCL_IRQ_W-1:0];
                    default: ;
                endcase
            end
            if (reg_rd) begin
                unique case (reg_addr)
                    BCL_CTRL_ADDR: begin
                        st_nxt.rdata_r[BCL_CTRL_CFD_OFF] = st.cfd_off_r;
                        st_nxt.rdata_r[BCL_CTRL_BKR_LSB +: 2] = st.bkr_sel_r;
                        st_nxt.rdata_r[BCL_CTRL_RCL_LSB +: 3] = st.rcl_r;
                    end
                    BCL_CFD_ADDR: st_nxt.rdata_r[CNT_W-1:0] = st.cfd_r;
                    BCL_STAT_ADDR: st_nxt.rdata_r = stat_c;
                    BCL_ISTAT_ADDR: st_nxt.rdata_r[BCL_IRQ_W-1:0] = st.ist_r;
                    BCL_IMASK_ADDR: st_nxt.rdata_r[BCL_IRQ_W-1:0] = st.imask_r;
                    default: st_nxt.rdata_r = '0;
                endcase
            end
            st_nxt.irq_r = |(st_nxt.ist_r & st_nxt.imask_r);
        end else begin
            st_nxt.rdata_r = st.rdata_r;
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            st <= '0;
            st.cfd_off_r <= BCL_CFD_OFF_RST;
            st.bkr_sel_r <= BCL_BKR_OPTO;
            st.rcl_r <= BCL_RCL_RST;
            st.cfd_r <= BCL_CFD_RST[CNT_W-1:0];
        end else begin
            st <= st_nxt;
        end
    end

    assign close_output_contact = st.close_r;
    assign breaker_closed_status = st.bkr_r;
    assign close_fail_flag = st.cf_r;
    assign reclose_active = st.rcl_act_r;
    assign irq = st.irq_r;
    assign reg_rdata = st.rdata_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    property p_set_block;
        ce && !st.close_r && (unlatch_close_cond_c || bkr_c || ri_rise_c || st.cf_r) |=> !st.close_r;
    endproperty
    a_set_block: assert property (p_set_block) else $error("close set while blocked");

    property p_set_event;
        ce && !st.close_r && set_ok_c && (cl_rise_c || rcl_tmo_c) |=> st.close_r;
    endproperty
    a_set_event: assert property (p_set_event) else $error("close not set on event");

    property p_unlatch;
        ce && st.close_r && (unlatch_close_cond_c || bkr_c || ri_rise_c) |=> !st.close_r;
    endproperty
    a_unlatch: assert property (p_unlatch) else $error("close not cleared");

    property p_cfd_off;
        ce && st.cfd_off_r |-> !tmo_c ##1 st.cnt_r == '0;
    endproperty
    a_cfd_off: assert property (p_cfd_off) else $error("failure timer ran while off");

    property p_max_high;
        st.close_r && !st.cfd_off_r && $stable(st.cfd_r) |-> st.cnt_r < st.cfd_r;
    endproperty
    a_max_high: assert property (p_max_high) else $error("close held past failure time");

    property p_fail_drop;
        ce && tmo_c |=> st.cf_r && !st.close_r;
    endproperty
    a_fail_drop: assert property (p_fail_drop) else $error("failure did not drop close");

    property p_trip_hold;
        ce && (ins.trip_bit || ins.diff_trip_bit) |=> !st.close_r;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("close high during trip");

    property p_inop;
        ce && st.bkr_sel_r == BCL_BKR_ZERO && !st.close_r |=> !st.close_r && !st.rcl_act_r;
    endproperty
    a_inop: assert property (p_inop) else $error("close logic active with status zero");

    property p_bkr_bit;
        ce |=> st.bkr_r == $past(bkr_c);
    endproperty
    a_bkr_bit: assert property (p_bkr_bit) else $error("status bit not evaluated equation");

    property p_cl_indep;
        ce && st.rcl_r == BCL_RCL_OFF && !st.close_r && set_ok_c && cl_rise_c |=> st.close_r;
    endproperty
    a_cl_indep: assert property (p_cl_indep) else $error("reclose off blocked close");

    property p_rcl_qual;
        ce && !st.close_r && !cl_rise_c && !ins.reclose_supervision_cond |=> !st.close_r;
    endproperty
    a_rcl_qual: assert property (p_rcl_qual) else $error("unsupervised reclose closed");

    property p_rcl_range;
        st.rcl_r <= BCL_RCL_MAX;
    endproperty
    a_rcl_range: assert property (p_rcl_range) else $error("reclose setting out of range");

    property p_freeze;
        !ce |=> $stable(st.close_r) && $stable(st.cnt_r) && $stable(st.ist_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved without enable");

    property p_timer_start;
        ce && !st.close_r ##1 st.close_r |-> st.cnt_r == '0;
    endproperty
    a_timer_start: assert property (p_timer_start) else $error("timer not zero at close rise");

    property p_no_event;
        ce && !st.close_r && !cl_rise_c && !rcl_tmo_c |=> !st.close_r;
    endproperty
    a_no_event: assert property (p_no_event) else $error("close set without event");

    property p_fail_pulse;
        ce && st.cf_r |=> !st.cf_r;
    endproperty
    a_fail_pulse: assert property (p_fail_pulse) else $error("failure flag longer than one interval");

    property p_opto_direct;
        ce && st.bkr_sel_r == BCL_BKR_OPTO |=> st.bkr_r == $past(ins.opto_input_one);
    endproperty
    a_opto_direct: assert property (p_opto_direct) else $error("status not taken from opto input");

    property p_opto_inv;
        ce && st.bkr_sel_r == BCL_BKR_OPTO_INV |=> st.bkr_r == !$past(ins.opto_input_one);
    endproperty
    a_opto_inv: assert property (p_opto_inv) else $error("inverted contact not inverted");

    property p_rcl_off;
        ce && st.rcl_r == BCL_RCL_OFF |=> !st.rcl_act_r;
    endproperty
    a_rcl_off: assert property (p_rcl_off) else $error("reclose active while off");

    property p_timer_clear;
        ce && (!st.close_r || st.cfd_off_r) |=> st.cnt_r == '0;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("failure timer not cleared");

    property p_set_flag;
        ce && !st.close_r && set_ok_c && set_ev_c |=> st.ist_r[BCL_IRQ_SET];
    endproperty
    a_set_flag: assert property (p_set_flag) else $error("close set event not recorded");

    property p_ist_sticky;
        ce && !(reg_rd && reg_addr == BCL_ISTAT_ADDR) |=> (st.ist_r & $past(st.ist_r)) == $past(st.ist_r);
    endproperty
    a_ist_sticky: assert property (p_ist_sticky) else $error("status bit lost without read");

    property p_irq_level;
        ce |=> st.irq_r == |(st.ist_r & st.imask_r);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt not level of masked status");

    property p_rdata_drop;
        ce && !reg_rd |=> st.rdata_r == '0;
    endproperty
    a_rdata_drop: assert property (p_rdata_drop) else $error("read data stood past its cycle");

endmodule

// ---- core/bcl_pkg.sv ----
/*
 * Package for the breaker close latch: register map, field positions,
 * reset values, settings encodings and the grouped input carrier.
 * Assumes one processing interval per enabled clock of the owning block.
 */
package bcl_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int BCL_AW = 8;
    localparam int BCL_DW = 32;
    localparam logic [7:0] BCL_CTRL_ADDR = 8'h00;
    localparam logic [7:0] BCL_CFD_ADDR = 8'h04;
    localparam logic [7:0] BCL_STAT_ADDR = 8'h08;
    localparam logic [7:0] BCL_ISTAT_ADDR = 8'h0c;
    localparam logic [7:0] BCL_IMASK_ADDR = 8'h10;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int BCL_CTRL_CFD_OFF = 0;
    localparam int BCL_CTRL_BKR_LSB = 1;
    localparam int BCL_CTRL_RCL_LSB = 3;
    localparam int BCL_STAT_CLOSE = 0;
    localparam int BCL_STAT_BKR = 1;
    localparam int BCL_STAT_FAIL = 2;
    localparam int BCL_STAT_RCL = 3;
    localparam int BCL_STAT_INOP = 4;
    localparam int BCL_IRQ_SET = 0;
    localparam int BCL_IRQ_FAIL = 1;
    localparam int BCL_IRQ_BKR = 2;
    localparam int BCL_IRQ_W = 3;

    // ---------------------------------------------------------------
    // Settings encodings and reset values
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        BCL_BKR_OPTO = 2'h0,
        BCL_BKR_OPTO_INV = 2'h1,
        BCL_BKR_ZERO = 2'h2,
        BCL_BKR_ONE = 2'h3
    } bcl_bkr_sel_e;

    localparam logic [2:0] BCL_RCL_OFF = 3'h0;
    localparam logic [2:0] BCL_RCL_MAX = 3'h4;
    localparam logic [2:0] BCL_RCL_RST = 3'h0;
    localparam logic BCL_CFD_OFF_RST = 1'b0;
    // Close failure time in processing intervals
    localparam int BCL_CFD_TIME = 60;
    localparam logic [15:0] BCL_CFD_RST = 16'h003c;

    // ---------------------------------------------------------------
    // Grouped inputs from breaker contacts, trip logic and commands
    // ---------------------------------------------------------------
    typedef struct packed {
        logic opto_input_one;
        logic close_cmd_bit;
        logic trip_bit;
        logic diff_trip_bit;
        logic reclose_initiate;
        logic open_interval_tmo;
        logic reclose_supervision_cond;
    } bcl_in_s;

endpackage

// ---- tb/bcl_breaker_model.sv ----
/* Breaker model: auxiliary contact and close coil of the breaker.
   Assumes the close output is sampled on clk_sys. */
`timescale 1ns/1ps
module bcl_breaker_model #(
    parameter int CLOSE_DLY = 4
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic close_output_contact,
    input wire logic nc_contact,
    input wire logic stuck,
    input wire logic open_req,
    output logic opto_input_one
);
    logic closed_r;
    int cnt;
    // Breaker closes once the coil has been energised CLOSE_DLY cycles
    always @(posedge clk_sys) begin
        if (!rst_b || open_req) begin
            closed_r <= 1'b0;
            cnt <= 0;
        end else if (close_output_contact && !stuck) begin
            cnt <= cnt + 1;
            if (cnt == CLOSE_DLY - 1) begin
                closed_r <= 1'b1;
            end
        end else begin
            cnt <= 0;
        end
    end
    // A normally-closed contact reads high while the breaker is open
    assign opto_input_one = closed_r ^ nc_contact;
endmodule

// ---- tb/tb.sv ----
/* Self-checking bench for the breaker close latch.
   Assumes the breaker model of bcl_breaker_model.sv on the far side. */
`timescale 1ns/1ps
module tb;
    import bcl_pkg::*;
    typedef struct packed {logic [1:0] sel; logic trip; logic diff; logic ri; logic exp;} bcl_row_s;
    bcl_row_s rows [7] = '{6'h01, 6'h08, 6'h04, 6'h02, 6'h30, 6'h20, 6'h11};
    logic [7:0] rst_a [6] = '{BCL_CTRL_ADDR, BCL_CFD_ADDR, BCL_STAT_ADDR, BCL_ISTAT_ADDR, BCL_IMASK_ADDR, 8'h14};
    logic [31:0] rst_v [6] = '{32'h0, 32'h3c, 32'h0, 32'h0, 32'h0, 32'h0};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rv;
    bcl_in_s drv = '0;
    bcl_in_s ins;
    logic opto, close_o, bkr, fail_o, rcl_o, irq;
    logic nc = 1'b0;
    logic stuck = 1'b0;
    logic open_req = 1'b0;
    logic ce = 1'b1;
    int fails = 0;
    int num_checks = 0;
    int n;

    always #5 clk_sys = ~clk_sys;
    always_comb begin
        ins = drv;
        ins.opto_input_one = opto;
    end

    bcl_close_latch dut (.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ins(ins),
        .close_output_contact(close_o), .breaker_closed_status(bkr), .close_fail_flag(fail_o),
        .reclose_active(rcl_o), .irq(irq));
    bcl_breaker_model brk (.clk_sys(clk_sys), .rst_b(rst_b), .close_output_contact(close_o),
        .nc_contact(nc), .stuck(stuck), .open_req(open_req), .opto_input_one(opto));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wr(BCL_CTRL_ADDR, 32'(rows[i].sel) << BCL_CTRL_BKR_LSB);
            nc <= (rows[i].sel == BCL_BKR_OPTO_INV);
            drv.trip_bit <= rows[i].trip;
            drv.diff_trip_bit <= rows[i].diff;
            cyc(3);
            @(posedge clk_sys);
            drv.close_cmd_bit <= 1'b1;
            drv.reclose_initiate <= rows[i].ri;
            cyc(1);
            chk("close", close_o, rows[i].exp);
            cyc(8);
            chk("close after breaker", close_o, 1'b0);
            chk("status", bkr, rows[i].exp | (rows[i].sel == BCL_BKR_ONE));
            @(posedge clk_sys);
            drv <= '0;
            open_req <= 1'b1;
            @(posedge clk_sys);
            open_req <= 1'b0;
        end
        // Breaker never closes: failure timer must end the close
        stuck <= 1'b1;
        nc <= 1'b0;
        wr(BCL_CTRL_ADDR, 32'h0);
        wr(BCL_CFD_ADDR, 32'h5);
        rd(BCL_ISTAT_ADDR);
        chk("istat events", rv, 32'h5);
        wr(BCL_IMASK_ADDR, 32'h1 << BCL_IRQ_FAIL);
        @(posedge clk_sys);
        drv.close_cmd_bit <= 1'b1;
        cyc(1);
        chk("close set", close_o, 1'b1);
        cyc(1);
        chk("masked irq", irq, 1'b0);
        n = 2;
        for (int i = 0; i < 40 && close_o === 1'b1; i++) begin
            cyc(1);
            if (close_o === 1'b1) begin
                n++;
            end
        end
        if (close_o === 1'b1) begin
            fails++;
            conclude();
        end
        chk("fail pulse", fail_o, 1'b1);
        chk("high intervals", n, 5);
        cyc(2);
        chk("irq", irq, 1'b1);
        rd(BCL_ISTAT_ADDR);
        chk("istat", rv, 32'h3);
        cyc(1);
        chk("irq clear", irq, 1'b0);
        @(posedge clk_sys);
        drv.close_cmd_bit <= 1'b0;
        wr(BCL_CTRL_ADDR, 32'h1 << BCL_CTRL_CFD_OFF);
        @(posedge clk_sys);
        drv.close_cmd_bit <= 1'b1;
        cyc(20);
        chk("timer off", close_o, 1'b1);
        chk("no fail", fail_o, 1'b0);
        @(posedge clk_sys);
        drv.reclose_initiate <= 1'b1;
        cyc(2);
        chk("initiate clears", close_o, 1'b0);
        for (int r = 0; r < 5; r++) begin
            wr(BCL_CTRL_ADDR, 32'(r) << BCL_CTRL_RCL_LSB);
            drv <= '0;
            cyc(2);
            chk("reclose active", rcl_o, r != 0);
            @(posedge clk_sys);
            drv.open_interval_tmo <= 1'b1;
            drv.reclose_supervision_cond <= (r != 1);
            cyc(2);
            chk("reclose close", close_o, r > 1);
            @(posedge clk_sys);
            drv.trip_bit <= 1'b1;
            cyc(2);
            chk("unlatch", close_o, 1'b0);
        end
        wr(BCL_CTRL_ADDR, 32'h5 << BCL_CTRL_RCL_LSB);
        rd(BCL_CTRL_ADDR);
        chk("reclose range", rv, 32'h4 << BCL_CTRL_RCL_LSB);
        wr(BCL_CTRL_ADDR, (32'h2 << BCL_CTRL_RCL_LSB) | (32'(BCL_BKR_ZERO) << BCL_CTRL_BKR_LSB));
        cyc(2);
        chk("defeated", rcl_o, 1'b0);
        rd(BCL_STAT_ADDR);
        chk("inoperable", rv, 32'h1 << BCL_STAT_INOP);
        cyc(1);
        chk("rdata drop", reg_rdata, 32'h0);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        cyc(2);
        chk("close in reset", close_o, 1'b0);
        @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(BCL_STAT_ADDR, 32'hffffffff);
        foreach (rst_a[i]) begin
            rd(rst_a[i]);
            chk("reset value", rv, rst_v[i]);
        end
        // Clock enable low freezes the latch and its edge memory
        @(posedge clk_sys);
        drv <= '0;
        ce <= 1'b0;
        @(posedge clk_sys);
        drv.close_cmd_bit <= 1'b1;
        cyc(3);
        chk("frozen close", close_o, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b1;
        cyc(1);
        chk("close after enable", close_o, 1'b1);
        conclude();
    end
endmodule
